// ### dtc_pkg.sv
// package for the dual timer/counter unit: register map and constants
package dtc_pkg;
	// register byte addresses on the bus
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_T0_LOW = 8'h08;
	localparam logic [7:0] ADDR_T0_HIGH = 8'h0C;
	localparam logic [7:0] ADDR_T1_LOW = 8'h10;
	localparam logic [7:0] ADDR_T1_HIGH = 8'h14;
	localparam logic [7:0] ADDR_SERVICE = 8'h18;
	localparam logic [7:0] ADDR_PINS = 8'h1C;
	// control register bit positions
	localparam int CTL_T1_FLAG = 7;
	localparam int CTL_T1_RUN = 6;
	localparam int CTL_T0_FLAG = 5;
	localparam int CTL_T0_RUN = 4;
	localparam int CTL_E1_FLAG = 3;
	localparam int CTL_E1_TYPE = 2;
	localparam int CTL_E0_FLAG = 1;
	localparam int CTL_E0_TYPE = 0;
	// mode group layout, per four-bit group
	localparam int MOD_GATE = 3;
	localparam int MOD_SOURCE = 2;
	localparam int MOD_FIELD_HI = 1;
	localparam int MOD_FIELD_LO = 0;
	localparam int MOD_GROUP_T1 = 4;
	// service acknowledge bits (write one)
	localparam int SVC_T0 = 0;
	localparam int SVC_T1 = 1;
	localparam int SVC_E0 = 2;
	localparam int SVC_E1 = 3;
	// reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	// machine cycle in processor clocks
	localparam int MACHINE_CLOCKS = 12;
	localparam logic [3:0] MACHINE_LAST = 4'(MACHINE_CLOCKS - 1);
	// mode codes
	localparam logic [1:0] MODE_13BIT = 2'h0;
	localparam logic [1:0] MODE_16BIT = 2'h1;
	localparam logic [1:0] MODE_RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ### dtc_timer_unit.sv
// dual timer/counter unit with an ahb-lite register slave
//
// Notes on behaviour
// - two independent 16-bit timer/counters, each set to timing or counting
// - timing advances once per machine cycle of twelve clocks
// - counting advances on a falling edge of the count input
// - edge recognition spans two machine cycles; max rate one per 24 clocks
// - overflow sets flag; software or interrupt service clears it
// - timer counts only while its run bit is set; stop keeps count
// - falling edge on external pin sets its edge flag; service clears it
// - trigger-type bit picks falling edge or low level for the request
// - gating set: count only while external pin high and run set
// - source bit one counts events, zero counts machine cycles
// - two-bit mode field selects modes 0 to 3
// - mode 0: 13-bit count, low byte upper three bits held zero
// - mode 2: low byte counts, reloads from high byte on overflow
// - mode 3 stops timer 1; splits timer 0 into two 8-bit counters
// - split: low byte uses timer 0 controls, high byte timer 1 run/flag
`timescale 1ns/1ns
module dtc_timer_unit
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// pins
	input wire logic timerZeroCountInput,
	input wire logic timerOneCountInput,
	input wire logic extZeroPin,
	input wire logic extOnePin,
	// requests toward the interrupt controller
	output logic timerZeroRequest,
	output logic timerOneRequest,
	output logic extZeroRequest,
	output logic extOneRequest
);
	logic [7:0] control_reg;
	logic [7:0] mode_reg;
	logic [7:0] countLow_reg [2];
	logic [7:0] countHigh_reg [2];
	logic [3:0] phase_reg;
	logic machineTick;
	logic [1:0] cntSample_reg;
	logic [1:0] cntPrev_reg;
	logic [1:0] extSample_reg;
	logic [1:0] extPrev_reg;
	logic [1:0] countEdge;
	logic [1:0] extFall;
	logic [1:0] advance;
	logic [1:0] wrapLow;
	logic [1:0] wrapFull;
	logic splitHighStep;
	logic splitHighWrap;
	logic [1:0] overflow;
	logic wrPending_reg;
	logic [7:0] wrAddr_reg;
	logic [7:0] wdata;
	logic [3:0] svc;
	logic [31:0] rdataNext;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign wdata = hwdata[7:0];

	// machine cycle divider
	always_ff @(posedge clock)
	begin
		if (rst || phase_reg == dtc_pkg::MACHINE_LAST)
			phase_reg <= 4'h0;
		else
			phase_reg <= phase_reg + 4'h1;
	end
	assign machineTick = (phase_reg == dtc_pkg::MACHINE_LAST);

	// pins sampled once per machine cycle; edge seen across two samples
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cntSample_reg <= 2'h3;
			cntPrev_reg <= 2'h3;
			extSample_reg <= 2'h3;
			extPrev_reg <= 2'h3;
		end
		else if (machineTick)
		begin
			cntPrev_reg <= cntSample_reg;
			cntSample_reg <= {timerOneCountInput, timerZeroCountInput};
			extPrev_reg <= extSample_reg;
			extSample_reg <= {extOnePin, extZeroPin};
		end
	end

	// per-timer advance condition
	for (genvar i = 0; i < 2; i++)
	begin : g_adv
		logic [3:0] grp;
		logic run;
		assign grp = mode_reg[i*dtc_pkg::MOD_GROUP_T1 +: 4];
		assign run = (i == 0) ? control_reg[dtc_pkg::CTL_T0_RUN]
			: control_reg[dtc_pkg::CTL_T1_RUN];
		assign countEdge[i] = machineTick && cntPrev_reg[i]
			&& !cntSample_reg[i];
		assign extFall[i] = machineTick && extPrev_reg[i] && !extSample_reg[i];
		assign advance[i] = run
			&& (!grp[dtc_pkg::MOD_GATE] || extSample_reg[i])
			&& (grp[dtc_pkg::MOD_SOURCE] ? countEdge[i] : machineTick)
			&& !(i == 1 && grp[1:0] == dtc_pkg::MODE_SPLIT);
		assign wrapLow[i] = advance[i] && countLow_reg[i] == 8'hFF;
		// low five bits plus high byte form 13 bits
		assign wrapFull[i] = advance[i] && countHigh_reg[i] == 8'hFF
			&& (grp[1:0] == dtc_pkg::MODE_13BIT
			? countLow_reg[i][4:0] == 5'h1F : countLow_reg[i] == 8'hFF);
	end

	// split mode high byte of timer 0 runs on timer 1 run, machine cycles
	assign splitHighStep = mode_reg[1:0] == dtc_pkg::MODE_SPLIT
		&& control_reg[dtc_pkg::CTL_T1_RUN] && machineTick;
	assign splitHighWrap = splitHighStep && countHigh_reg[0] == 8'hFF;

	// overflow per flag
	always_comb
	begin
		overflow = 2'h0;
		for (int i = 0; i < 2; i++)
		begin
			case (mode_reg[i*4 +: 2])
				dtc_pkg::MODE_RELOAD: overflow[i] = wrapLow[i];
				dtc_pkg::MODE_SPLIT: overflow[i] = (i == 0) ? wrapLow[0] : 1'b0;
				default: overflow[i] = wrapFull[i];
			endcase
		end
		if (splitHighWrap)
			overflow[1] = 1'b1;
	end

	// bus write data phase capture
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wrPending_reg <= 1'b0;
			wrAddr_reg <= 8'h00;
		end
		else if (hready)
		begin
			wrPending_reg <= hsel && htrans == dtc_pkg::HTRANS_NONSEQ && hwrite;
			wrAddr_reg <= haddr;
		end
	end
	assign svc = (wrPending_reg && wrAddr_reg == dtc_pkg::ADDR_SERVICE)
		? wdata[3:0] : 4'h0;

	// counters
	for (genvar i = 0; i < 2; i++)
	begin : g_cnt
		logic wrLow;
		logic wrHigh;
		logic [1:0] md;
		assign wrLow = wrPending_reg && wrAddr_reg ==
			((i == 0) ? dtc_pkg::ADDR_T0_LOW : dtc_pkg::ADDR_T1_LOW);
		assign wrHigh = wrPending_reg && wrAddr_reg ==
			((i == 0) ? dtc_pkg::ADDR_T0_HIGH : dtc_pkg::ADDR_T1_HIGH);
		assign md = mode_reg[i*4 +: 2];
		always_ff @(posedge clock)
		begin
			if (rst)
			begin
				countLow_reg[i] <= dtc_pkg::COUNT_RESET;
				countHigh_reg[i] <= dtc_pkg::COUNT_RESET;
			end
			else
			begin
				if (wrLow)
					countLow_reg[i] <= wdata;
				else if (md == dtc_pkg::MODE_13BIT && advance[i])
					countLow_reg[i] <= {3'h0, countLow_reg[i][4:0] + 5'h1};
				else if (md == dtc_pkg::MODE_RELOAD && wrapLow[i])
					countLow_reg[i] <= countHigh_reg[i];
				else if (advance[i])
					countLow_reg[i] <= countLow_reg[i] + 8'h01;
				if (wrHigh)
					countHigh_reg[i] <= wdata;
				else if (i == 0 && md == dtc_pkg::MODE_SPLIT)
				begin
					if (splitHighStep)
						countHigh_reg[i] <= countHigh_reg[i] + 8'h01;
				end
				else if (md == dtc_pkg::MODE_13BIT && advance[i]
					&& countLow_reg[i][4:0] == 5'h1F)
					countHigh_reg[i] <= countHigh_reg[i] + 8'h01;
				else if (md == dtc_pkg::MODE_16BIT && wrapLow[i])
					countHigh_reg[i] <= countHigh_reg[i] + 8'h01;
			end
		end
	end

	// mode register
	always_ff @(posedge clock)
	begin
		if (rst)
			mode_reg <= dtc_pkg::MODE_RESET;
		else if (wrPending_reg && wrAddr_reg == dtc_pkg::ADDR_MODE)
			mode_reg <= wdata;
	end

	// control register; hardware set beats software clear
	always_ff @(posedge clock)
	begin
		logic [7:0] c;
		c = control_reg;
		if (rst)
			control_reg <= dtc_pkg::CONTROL_RESET;
		else
		begin
			if (wrPending_reg && wrAddr_reg == dtc_pkg::ADDR_CONTROL)
				c = wdata;
			if (svc[dtc_pkg::SVC_T0])
				c[dtc_pkg::CTL_T0_FLAG] = 1'b0;
			if (svc[dtc_pkg::SVC_T1])
				c[dtc_pkg::CTL_T1_FLAG] = 1'b0;
			if (svc[dtc_pkg::SVC_E0])
				c[dtc_pkg::CTL_E0_FLAG] = 1'b0;
			if (svc[dtc_pkg::SVC_E1])
				c[dtc_pkg::CTL_E1_FLAG] = 1'b0;
			if (overflow[0])
				c[dtc_pkg::CTL_T0_FLAG] = 1'b1;
			if (overflow[1])
				c[dtc_pkg::CTL_T1_FLAG] = 1'b1;
			if (extFall[0])
				c[dtc_pkg::CTL_E0_FLAG] = 1'b1;
			if (extFall[1])
				c[dtc_pkg::CTL_E1_FLAG] = 1'b1;
			control_reg <= c;
		end
	end

	// interrupt requests: timer overflow flags; external edge flag or low level
	assign timerZeroRequest = control_reg[dtc_pkg::CTL_T0_FLAG];
	assign timerOneRequest = control_reg[dtc_pkg::CTL_T1_FLAG];
	assign extZeroRequest = control_reg[dtc_pkg::CTL_E0_TYPE]
		? control_reg[dtc_pkg::CTL_E0_FLAG] : !extSample_reg[0];
	assign extOneRequest = control_reg[dtc_pkg::CTL_E1_TYPE]
		? control_reg[dtc_pkg::CTL_E1_FLAG] : !extSample_reg[1];

	// read data, registered at the address phase
	always_comb
	begin
		rdataNext = 32'h0;
		case (haddr)
			dtc_pkg::ADDR_CONTROL: rdataNext[7:0] = control_reg;
			dtc_pkg::ADDR_MODE: rdataNext[7:0] = mode_reg;
			dtc_pkg::ADDR_T0_LOW: rdataNext[7:0] = countLow_reg[0];
			dtc_pkg::ADDR_T0_HIGH: rdataNext[7:0] = countHigh_reg[0];
			dtc_pkg::ADDR_T1_LOW: rdataNext[7:0] = countLow_reg[1];
			dtc_pkg::ADDR_T1_HIGH: rdataNext[7:0] = countHigh_reg[1];
			dtc_pkg::ADDR_PINS: rdataNext[3:0] = {extSample_reg, cntSample_reg};
			default: rdataNext = 32'h0;
		endcase
	end
	always_ff @(posedge clock)
	begin
		if (rst)
			hrdata <= 32'h0;
		else if (hready && hsel && htrans == dtc_pkg::HTRANS_NONSEQ && !hwrite)
			hrdata <= rdataNext;
	end

	// checks
	a_tick_period: assert property (
		@(posedge clock) disable iff (rst)
		machineTick |=> !machineTick [*8])
		else $error("machine tick too frequent");
	a_tick_due: assert property (
		@(posedge clock) disable iff (rst)
		machineTick |-> ##12 machineTick)
		else $error("machine tick missing");
	a_stop_holds: assert property (
		@(posedge clock) disable iff (rst)
		!control_reg[dtc_pkg::CTL_T0_RUN] && !wrPending_reg
		|=> $stable(countLow_reg[0]))
		else $error("stopped timer changed");
	a_flag_sets: assert property (
		@(posedge clock) disable iff (rst)
		overflow[0] |=> control_reg[dtc_pkg::CTL_T0_FLAG])
		else $error("overflow flag not set");
	a_service_clears: assert property (
		@(posedge clock) disable iff (rst)
		svc[dtc_pkg::SVC_T0] && !overflow[0]
		|=> !control_reg[dtc_pkg::CTL_T0_FLAG])
		else $error("serviced flag still set");
	a_ext_edge: assert property (
		@(posedge clock) disable iff (rst)
		extFall[1] |=> control_reg[dtc_pkg::CTL_E1_FLAG])
		else $error("edge flag not set");
	a_level_req: assert property (
		@(posedge clock) disable iff (rst)
		!control_reg[dtc_pkg::CTL_E1_TYPE] && !extSample_reg[1]
		|-> extOneRequest)
		else $error("low level gave no request");
	a_mode0_top: assert property (
		@(posedge clock) disable iff (rst)
		mode_reg[1:0] == dtc_pkg::MODE_13BIT && !$past(wrPending_reg)
		&& $past(mode_reg[1:0]) == dtc_pkg::MODE_13BIT
		&& $past(advance[0]) |-> countLow_reg[0][7:5] == 3'h0)
		else $error("13-bit low byte upper bits set");
	a_mode0_carry: assert property (
		@(posedge clock) disable iff (rst)
		mode_reg[1:0] == dtc_pkg::MODE_13BIT && advance[0]
		&& countLow_reg[0][4:0] == 5'h1F && !wrPending_reg
		|=> countLow_reg[0][4:0] == 5'h00
		&& countHigh_reg[0] == $past(countHigh_reg[0]) + 8'h01)
		else $error("13-bit carry lost");
	a_reload_low: assert property (
		@(posedge clock) disable iff (rst)
		mode_reg[1:0] == dtc_pkg::MODE_RELOAD && wrapLow[0] && !wrPending_reg
		|=> countLow_reg[0] == $past(countHigh_reg[0]))
		else $error("reload missed");
	a_t1_split_stop: assert property (
		@(posedge clock) disable iff (rst)
		mode_reg[5:4] == dtc_pkg::MODE_SPLIT && !wrPending_reg
		|=> $stable(countLow_reg[1]) && $stable(countHigh_reg[1]))
		else $error("timer one ran in mode three");
	a_split_high: assert property (
		@(posedge clock) disable iff (rst)
		splitHighWrap && !wrPending_reg
		|=> countHigh_reg[0] == 8'h00 && control_reg[dtc_pkg::CTL_T1_FLAG])
		else $error("split high byte wrap missed");
	a_wrap_full: assert property (
		@(posedge clock) disable iff (rst)
		mode_reg[1:0] == dtc_pkg::MODE_16BIT && !wrPending_reg
		&& advance[0] && countLow_reg[0] == 8'hFF
		&& countHigh_reg[0] == 8'hFF
		|=> {countHigh_reg[0], countLow_reg[0]} == 16'h0000)
		else $error("16-bit count did not wrap");
	a_event_edge: assert property (
		@(posedge clock) disable iff (rst)
		advance[0] && mode_reg[dtc_pkg::MOD_SOURCE]
		|-> cntPrev_reg[0] && !cntSample_reg[0])
		else $error("count without falling edge");
	a_gate_low: assert property (
		@(posedge clock) disable iff (rst)
		mode_reg[dtc_pkg::MOD_GATE] && !extSample_reg[0]
		|-> !advance[0])
		else $error("gated timer counted");
endmodule // dtc_timer_unit

// ### dtc_pin_source.sv
// model of the external count pins feeding the timer unit
`timescale 1ns/1ns
module dtc_pin_source
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// burst request from the bench
	input wire logic go,
	input wire logic sel,
	input wire logic [3:0] pulses,
	// count pins, idle high; busy while a burst runs
	output logic cnt0,
	output logic cnt1,
	output logic busy
);
	logic [3:0] left_reg;
	logic [5:0] phase_reg;
	logic low;
	always_ff @(posedge clock)
	begin
		if (rst || left_reg == 4'h0)
		begin
			left_reg <= (rst || !go) ? 4'h0 : pulses;
			phase_reg <= 6'h00;
		end
		else
		begin
			phase_reg <= (phase_reg == 6'h2F) ? 6'h00 : phase_reg + 6'h01;
			if (phase_reg == 6'h2F)
				left_reg <= left_reg - 4'h1;
		end
	end
	// each level held 24 clocks, two machine cycles
	assign low = (left_reg != 4'h0) && (phase_reg < 6'h18);
	assign cnt0 = !(low && !sel);
	assign cnt1 = !(low && sel);
	assign busy = left_reg != 4'h0;
endmodule // dtc_pin_source

// ### dual_timer_counter_unit_tb.sv
// self-checking bench for the dual timer/counter unit
`timescale 1ns/1ns
module dual_timer_counter_unit_tb;
	localparam logic [7:0] CT = dtc_pkg::ADDR_CONTROL;
	localparam logic [7:0] SV = dtc_pkg::ADDR_SERVICE;
	localparam logic [7:0] MD = dtc_pkg::ADDR_MODE;
	localparam logic [7:0] L0 = dtc_pkg::ADDR_T0_LOW;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] v;
	logic hreadyout;
	logic hresp;
	logic [1:0] extPins = 2'h3;
	logic cnt0;
	logic cnt1;
	logic busy;
	logic go = 1'b0;
	logic sel = 1'b0;
	logic [3:0] pulses = 4'h0;
	logic [3:0] req;
	int err_total = 0;
	int checks_done = 0;
	int cycles = 0;
	always #4 clock = ~clock;
	dtc_timer_unit DUT (.clock(clock), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .timerZeroCountInput(cnt0),
		.timerOneCountInput(cnt1), .extZeroPin(extPins[0]),
		.extOnePin(extPins[1]), .timerZeroRequest(req[0]),
		.timerOneRequest(req[1]), .extZeroRequest(req[2]),
		.extOneRequest(req[3]));
	dtc_pin_source pins (.clock(clock), .rst(rst), .go(go), .sel(sel),
		.pulses(pulses), .cnt0(cnt0), .cnt1(cnt1), .busy(busy));
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			summarize();
		end
	end
	task automatic check(input logic [31:0] seen, exp, input string what);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, d);
		hsel <= 1'b1;
		hwrite <= wr;
		haddr <= a;
		htrans <= dtc_pkg::HTRANS_NONSEQ;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clock); while (hreadyout !== 1'b1);
		v = hrdata;
	endtask
	task automatic rc(input logic [7:0] a, d, input string what);
		bus(1'b0, a, 8'h00);
		check(v, {24'h0, d}, what);
		check({31'h0, hresp}, 32'h0, "resp");
	endtask
	task automatic pulse(input logic s, input logic [3:0] n);
		sel <= s;
		pulses <= n;
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		@(posedge clock);
		while (busy === 1'b1) @(posedge clock);
		// last falling edge needs two machine cycles to register
		repeat (24) @(posedge clock);
	endtask
	task automatic tcase(input int i, input logic [7:0] md, run, lo, hi,
		input logic [3:0] n, input logic [7:0] eLo, eHi, hm, eCt);
		logic [7:0] a;
		a = L0 + 8'(8 * i);
		bus(1'b1, MD, md);
		bus(1'b1, a, lo);
		bus(1'b1, a + 8'h04, hi);
		bus(1'b1, CT, run);
		pulse(i[0], n);
		bus(1'b1, CT, eCt);
		check({31'h0, req[i]}, 32'h1, "ovf request");
		rc(a, eLo, "lo");
		bus(1'b0, a + 8'h04, 8'h00);
		check(v & {24'h0, hm}, {24'h0, eHi & hm}, "hi");
		rc(CT, eCt, "ctl");
		bus(1'b1, SV, 8'h03);
		rc(CT, 8'h00, "cleared");
	endtask
	task automatic extWait(input logic [1:0] p);
		extPins <= p;
		repeat (36) @(posedge clock);
	endtask
	initial
	begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rc(CT, dtc_pkg::CONTROL_RESET, "ctl reset");
		rc(MD, dtc_pkg::MODE_RESET, "mode reset");
		rc(dtc_pkg::ADDR_T1_HIGH, dtc_pkg::COUNT_RESET, "count reset");
		rc(dtc_pkg::ADDR_PINS, 8'h0F, "pins");
		bus(1'b1, 8'h20, 8'hFF);
		rc(8'h20, 8'h00, "unmapped");
		bus(1'b1, MD, 8'h01);
		bus(1'b1, CT, 8'h10);
		repeat (118) @(posedge clock);
		bus(1'b1, CT, 8'h00);
		repeat (30) @(posedge clock);
		rc(L0, 8'h0A, "timed count");
		for (int i = 0; i < 2; i++)
			tcase(i, 8'h05 << (4 * i), 8'h10 << (2 * i), 8'hFE, 8'hFF, 4'h3,
				8'h01, 8'h00, 8'hFF, 8'h20 << (2 * i));
		tcase(0, 8'h04, 8'h10, 8'h1E, 8'hFF, 4'h3, 8'h01, 8'h00, 8'hFF,
			8'h20);
		tcase(0, 8'h26, 8'h10, 8'hFE, 8'hF0, 4'h3, 8'hF1, 8'hF0, 8'hFF,
			8'h20);
		bus(1'b1, dtc_pkg::ADDR_T1_LOW, 8'h55);
		tcase(0, 8'h37, 8'h50, 8'hFE, 8'hFF, 4'h2, 8'h00, 8'h00, 8'h00,
			8'hA0);
		rc(dtc_pkg::ADDR_T1_LOW, 8'h55, "stopped");
		bus(1'b1, MD, 8'h0D);
		bus(1'b1, L0, 8'h00);
		bus(1'b1, CT, 8'h10);
		extWait(2'h2);
		pulse(1'b0, 4'h2);
		rc(L0, 8'h00, "gated off");
		extWait(2'h3);
		pulse(1'b0, 4'h2);
		rc(L0, 8'h02, "gated on");
		bus(1'b1, CT, 8'h00);
		bus(1'b1, SV, 8'h0F);
		for (int i = 0; i < 2; i++)
		begin
			bus(1'b1, CT, 8'h01 << (2 * i));
			extWait(2'h3 ^ (2'h1 << i));
			rc(CT, 8'h03 << (2 * i), "edge flag");
			extWait(2'h3);
			check({31'h0, req[2 + i]}, 32'h1, "edge req");
			bus(1'b1, SV, 8'h04 << i);
			@(posedge clock);
			check({31'h0, req[2 + i]}, 32'h0, "serviced");
			bus(1'b1, CT, 8'h00);
			extWait(2'h3 ^ (2'h1 << i));
			check({31'h0, req[2 + i]}, 32'h1, "level req");
			extWait(2'h3);
			check({31'h0, req[2 + i]}, 32'h0, "level off");
			bus(1'b1, SV, 8'h0C);
		end
		summarize();
	end
endmodule // dual_timer_counter_unit_tb
